// ==== verilog/ics_defines.svh ====
// address map, status layout, reset values and timing counts of the channel slave
`ifndef ICS_DEFINES_SVH
`define ICS_DEFINES_SVH

// slave window on the 12-bit channel address
`define ICS_BASE_ADDR 12'h300
`define ICS_OFS_DATA 12'h000
`define ICS_OFS_STATUS 12'h001
`define ICS_OFS_CLEAR 12'h002

// status byte layout
`define ICS_ST_PEND_LSB 0
`define ICS_ST_PRIO_LSB 4
`define ICS_ST_ANY_BIT 7

// reset values and the byte returned by an unmapped read
`define ICS_PEND_RST 4'h0
`define ICS_DOUT_RST 8'h00
`define ICS_UNMAPPED_RD 8'h00

// timing: local clock period and the two clear deadlines
`define ICS_CLK_NS 50
`define ICS_RST_CLR_NS 10000
`define ICS_STB_CLR_NS 3000
`define ICS_RST_CLR_CYC (`ICS_RST_CLR_NS / `ICS_CLK_NS)
`define ICS_STB_CLR_CYC (`ICS_STB_CLR_NS / `ICS_CLK_NS)

// receive buffer shape
`define ICS_FIFO_WIDTH 8
`define ICS_FIFO_DEPTH 16

`endif

// ==== verilog/ics_pkg.sv ====
// types used by the channel slave; its receive buffer defines its own state type
package ics_pkg;

  // how a pending request is withdrawn besides channel reset
  typedef enum logic [1:0] {
    ICS_CLR_RESET = 2'b00,
    ICS_CLR_READ = 2'b01,
    ICS_CLR_WRITE = 2'b10
  } ics_clr_mode_t;

  // handshake sequencer
  typedef enum logic [1:0] {
    ICS_IDLE = 2'b00,
    ICS_ACK = 2'b01,
    ICS_SKIP = 2'b10
  } ics_fsm_t;

  // channel pins after inversion to active high
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic wr;
    logic strobe;
    logic chan_rst;
  } ics_pins_t;

  // complete state of the slave apart from its receive buffer
  typedef struct packed {
    ics_pins_t pin_s1;
    ics_pins_t pin_s2;
    ics_fsm_t fsm;
    logic [3:0] pend;
    logic ack;
    logic doe;
    logic [7:0] dout;
    logic push;
    logic [7:0] push_data;
  } ics_slv_st_t;

endpackage

// ==== verilog/ics_fifo.sv ====
// receive buffer: parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module ics_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic notfull;
    logic nonempty;
  } ics_fifo_st_t;

  ics_fifo_st_t s;
  ics_fifo_st_t n;
  logic do_wr;
  logic do_rd;
  logic [AW:0] cnt_nx;

  ////////////////////////////////////////////////////////////////////////
  // pointer and count update; flags registered so ports come from flops
  always_comb begin
    n = s;
    do_wr = in_valid_i & s.notfull;
    do_rd = out_ready_i & s.nonempty;
    cnt_nx = s.cnt;
    if (do_wr) begin
      n.mem[s.wp] = in_data_i;
      n.wp = s.wp + 1'b1;
    end
    if (do_rd) begin
      n.rp = s.rp + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_nx = s.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_nx = s.cnt - 1'b1;
    end
    n.cnt = cnt_nx;
    n.notfull = (cnt_nx != (AW+1)'(DEPTH));
    n.nonempty = (cnt_nx != '0);
  end

  // reset empties the buffer; notfull is a plain flop cleared to zero
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign in_ready_o = s.notfull;
  assign out_valid_o = s.nonempty;
  assign out_data_o = s.mem[s.rp];

endmodule

// ==== verilog/ics_slave.sv ====
// channel slave: strobe/acknowledge handshake, request lines, status byte, rx buffer
//
// Functional notes
// - only the master starts transfers; this slave only answers.
// - acknowledge is driven only by the addressed slave, accepting the transfer.
// - four request lines, line one lowest priority, line four highest.
// - a request, once driven low, stays low until the master services it.
// - status byte at a fixed address shows pending requests and their priority.
// - reset-clear mode: channel reset withdraws requests well within ten microseconds.
// - after channel reset no trace of earlier request state remains.
// - read-clear mode: reading the status byte releases requests within three microseconds.
// - the clearing read is an ordinary handshaked read.
// - write-clear mode: writing the clear location releases requests within three microseconds.
// - the clearing write is an ordinary handshaked write.
// - nothing here assumes any phase relation to the channel clock.
// - channel reset puts the slave into a defined initial state; the rx buffer keeps its bytes through it.
// - registers are selected by the 12-bit channel address.
// - data moves a byte at a time over the 8-bit two-way data path.
`timescale 1ns/10ps
`include "ics_defines.svh"
module ics_slave (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [11:0] chan_addr_i,
  input wire logic [7:0] chan_data_i,
  output logic [7:0] chan_data_o,
  output logic chan_data_oe_o,
  input wire logic write_sel_n_i,
  input wire logic xfer_strobe_n_i,
  output logic xfer_ack_n_o,
  output logic xfer_ack_oe_o,
  input wire logic chan_reset_n_i,
  output logic [3:0] irq_req_n_o,
  output logic [3:0] irq_req_oe_o,
  input wire logic [1:0] clr_mode_i,
  input wire logic [3:0] irq_raise_i,
  input wire logic [7:0] rd_byte_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when the channel address selects one location of this slave
  function automatic logic ics_hit(input logic [11:0] addr, input logic [11:0] ofs);
    logic [11:0] target;
    target = `ICS_BASE_ADDR + ofs;
    ics_hit = (addr == target);
  endfunction

  // highest pending line as 1..4, zero when nothing is pending
  function automatic logic [2:0] ics_prio(input logic [3:0] pend);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (pend[i]) begin
        lvl = 3'(i + 1);
      end
    end
    ics_prio = lvl;
  endfunction

  // status byte: pending bits low, priority field, summary bit on top
  function automatic logic [7:0] ics_status(input logic [3:0] pend);
    logic [7:0] b;
    b = 8'h00;
    b[`ICS_ST_PEND_LSB +: 4] = pend;
    b[`ICS_ST_PRIO_LSB +: 3] = ics_prio(pend);
    b[`ICS_ST_ANY_BIT] = |pend;
    ics_status = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  ics_pkg::ics_slv_st_t s;
  ics_pkg::ics_slv_st_t n;
  ics_pkg::ics_pins_t pin_now;
  ics_pkg::ics_clr_mode_t mode;

  logic fifo_ready;
  logic strobe_lo;
  logic is_wr;
  logic hit_data;
  logic hit_status;
  logic hit_clear;
  logic hit_any;
  logic [3:0] clr;

  // pins flipped to active high so an all-zero reset means idle bus
  always_comb begin
    pin_now.addr = chan_addr_i;
    pin_now.data = chan_data_i;
    pin_now.wr = ~write_sel_n_i;
    pin_now.strobe = ~xfer_strobe_n_i;
    pin_now.chan_rst = ~chan_reset_n_i;
  end

  // an unknown mode code falls back to reset-only clearing
  always_comb begin
    unique case (clr_mode_i)
      2'b01: mode = ics_pkg::ICS_CLR_READ;
      2'b10: mode = ics_pkg::ICS_CLR_WRITE;
      default: mode = ics_pkg::ICS_CLR_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of the synchronised transfer

  // only second-stage samples are looked at; first stage feeds nothing else
  always_comb begin
    strobe_lo = s.pin_s2.strobe;
    is_wr = s.pin_s2.wr;
    hit_data = ics_hit(s.pin_s2.addr, `ICS_OFS_DATA);
    hit_status = ics_hit(s.pin_s2.addr, `ICS_OFS_STATUS);
    hit_clear = ics_hit(s.pin_s2.addr, `ICS_OFS_CLEAR);
    hit_any = hit_data | hit_status | hit_clear;
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    n = s;
    clr = 4'h0;

    // two-flop synchronisers for every channel pin
    n.pin_s1 = pin_now;
    n.pin_s2 = s.pin_s1;

    // push is a one-cycle pulse toward the buffer
    n.push = 1'b0;

    unique case (s.fsm)
      ics_pkg::ICS_IDLE: begin
        if (strobe_lo) begin
          if (!hit_any) begin
            // not ours: leave acknowledge undriven, wait for strobe release
            n.fsm = ics_pkg::ICS_SKIP;
          end else if (is_wr && hit_data && !fifo_ready) begin
            // buffer full: withhold acknowledge, the master waits
            n.fsm = ics_pkg::ICS_IDLE;
          end else begin
            n.fsm = ics_pkg::ICS_ACK;
            n.ack = 1'b1;
            if (is_wr) begin
              if (hit_data) begin
                n.push = 1'b1;
                n.push_data = s.pin_s2.data;
              end
              if (hit_clear && mode == ics_pkg::ICS_CLR_WRITE) begin
                clr = s.pin_s2.data[3:0];
              end
            end else begin
              n.doe = 1'b1;
              if (hit_status) begin
                n.dout = ics_status(s.pend);
              end else if (hit_data) begin
                n.dout = rd_byte_i;
              end else begin
                n.dout = `ICS_UNMAPPED_RD;
              end
              if (hit_status && mode == ics_pkg::ICS_CLR_READ) begin
                clr = 4'hF;
              end
            end
          end
        end
      end

      ics_pkg::ICS_ACK: begin
        // four-phase: hold acknowledge and read data until strobe rises
        if (!strobe_lo) begin
          n.fsm = ics_pkg::ICS_IDLE;
          n.ack = 1'b0;
          n.doe = 1'b0;
        end
      end

      ics_pkg::ICS_SKIP: begin
        // a transfer for another slave; never decode it twice
        if (!strobe_lo) begin
          n.fsm = ics_pkg::ICS_IDLE;
        end
      end

      default: begin
        n.fsm = ics_pkg::ICS_IDLE;
        n.ack = 1'b0;
        n.doe = 1'b0;
      end
    endcase

    // sticky requests: a raise in the clearing cycle survives the clear
    n.pend = (s.pend & ~clr) | irq_raise_i;

    // channel reset initialises all but the rx buffer, the pin synchronisers and push_data: drop request history and the handshake.
    // acts three clock edges after the pin, far inside the reset deadline
    if (s.pin_s2.chan_rst) begin
      n.pend = `ICS_PEND_RST;
      n.fsm = ics_pkg::ICS_IDLE;
      n.ack = 1'b0;
      n.doe = 1'b0;
      n.dout = `ICS_DOUT_RST;
      n.push = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // all-zero reset: idle, no requests, nothing driven on the channel
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer for bytes written to the data location

  // full buffer stalls the handshake rather than dropping a byte
  ics_fifo #(
    .WIDTH(`ICS_FIFO_WIDTH),
    .DEPTH(`ICS_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(s.push),
    .in_data_i(s.push_data),
    .in_ready_o(fifo_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // open-drain style ack and request pins with level fixed low; data level and all enables come from flops

  assign xfer_ack_n_o = 1'b0;
  assign xfer_ack_oe_o = s.ack;
  assign irq_req_n_o = 4'h0;
  assign irq_req_oe_o = s.pend;
  assign chan_data_o = s.dout;
  assign chan_data_oe_o = s.doe;

endmodule

// ==== test/ics_asserts.sv ====
// concurrent checks on the channel slave ports
`timescale 1ns/10ps
module ics_asserts (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [11:0] chan_addr_i,
  input wire logic write_sel_n_i,
  input wire logic xfer_strobe_n_i,
  input wire logic xfer_ack_oe_o,
  input wire logic chan_data_oe_o,
  input wire logic chan_reset_n_i,
  input wire logic [3:0] irq_req_oe_o,
  input wire logic [1:0] clr_mode_i,
  input wire logic [3:0] irq_raise_i
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////
  // pins pass two sync flops, decode one edge later: three edges of lag
  AST_ACK_CAUSE: assert property (xfer_ack_oe_o |-> !$past(xfer_strobe_n_i, 3))
    else $error("ack without strobe");
  AST_ACK_DROP: assert property ($rose(xfer_strobe_n_i) |-> ##3 !xfer_ack_oe_o)
    else $error("ack held after strobe release");
  AST_ACK_ADDR: assert property ($rose(xfer_ack_oe_o) |->
    $past(chan_addr_i, 3) inside {[12'h300:12'h302]}) else $error("ack outside window");
  AST_RD_DRIVE: assert property ($rose(xfer_ack_oe_o) |->
    chan_data_oe_o == $past(write_sel_n_i, 3)) else $error("data drive wrong way");
  // channel reset wins over everything once synced
  AST_CHRST: assert property (!chan_reset_n_i [*4] |->
    irq_req_oe_o == 4'h0 && !xfer_ack_oe_o) else $error("channel reset ignored");
  AST_IRQ_HOLD: assert property ((($past(irq_req_oe_o) & ~irq_req_oe_o) != 4'h0) |->
    $rose(xfer_ack_oe_o) || !$past(chan_reset_n_i, 3)) else $error("request dropped early");
  AST_IRQ_SET: assert property ((irq_raise_i != 4'h0) && chan_reset_n_i &&
    $past(chan_reset_n_i) && $past(chan_reset_n_i, 2) |=>
    (irq_req_oe_o & $past(irq_raise_i)) == $past(irq_raise_i)) else $error("raise lost");
  AST_RD_CLEAR: assert property ($rose(xfer_ack_oe_o) && clr_mode_i == 2'b01 &&
    $past(write_sel_n_i, 3) && $past(chan_addr_i, 3) == 12'h301 &&
    $past(irq_raise_i) == 4'h0 |-> irq_req_oe_o == 4'h0) else $error("read clear late");
  cover property ($rose(xfer_ack_oe_o) && chan_data_oe_o);
  cover property ($rose(xfer_ack_oe_o) && !chan_data_oe_o);
  cover property ($fell(chan_reset_n_i));
endmodule
bind ics_slave ics_asserts u_chk (.clock_i, .reset_n_i, .chan_addr_i, .write_sel_n_i,
  .xfer_strobe_n_i, .xfer_ack_oe_o, .chan_data_oe_o, .chan_reset_n_i, .irq_req_oe_o,
  .clr_mode_i, .irq_raise_i);

// ==== test/ics_master.sv ====
// channel master model: four-phase strobe handshake; between cycles strobe and data are released, address and write select inverted
`timescale 1ns/10ps
module ics_master (
  input wire logic clock_i,
  input wire logic ack_i,
  input wire logic [7:0] sdata_i,
  input wire logic sdata_oe_i,
  output logic [11:0] addr_o,
  output logic [7:0] data_o,
  output logic wr_n_o,
  output logic stb_n_o
);
  logic [7:0] mdata;
  logic mdrive;
  logic chan_clk;
  int linger;
  // free-running 4 MHz channel clock; the slave has no pin for it and must not rely on it
  initial begin
    chan_clk = 1'b0;
    forever #125 chan_clk = ~chan_clk;
  end
  initial begin
    stb_n_o = 1'b1;
    addr_o = 12'h000;
    wr_n_o = 1'b1;
    mdata = 8'h00;
    mdrive = 1'b0;
    linger = 0;
  end
  // floating data bus shows the inverse of the master's last data byte
  always_comb begin
    data_o = sdata_oe_i ? sdata_i : (mdrive ? mdata : ~mdata);
  end
  // only this side opens a transfer; address settles a cycle before strobe
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 8'h00;
    @(posedge clock_i);
    #1 addr_o = a;
    wr_n_o = !wr;
    mdata = d;
    mdrive = wr;
    @(posedge clock_i);
    #1 stb_n_o = 1'b0;
    // look just after the edge so the registered ack and read data have settled
    while (!ok && n < 100) begin
      @(posedge clock_i);
      #1;
      n++;
      if (ack_i) begin
        ok = 1'b1;
        q = data_o;
      end
    end
    repeat (linger) @(posedge clock_i);
    #1 stb_n_o = 1'b1;
    while (ack_i && n < 200) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    #1 addr_o = ~a;
    wr_n_o = wr;
    mdrive = 1'b0;
  endtask
endmodule

// ==== test/tb_top.sv ====
// testbench: master traffic, clearing modes and rx buffer against a queue model
`timescale 1ns/10ps
module tb_top;
  logic clock_i, reset_n_i, chan_reset_n_i, rx_ready_i, ackoe, ackn, cdoe, rxv, ok, stb_n, wr_n;
  logic [11:0] addr;
  logic [7:0] bus, cdo, rdb, rxd, q, d;
  logic [3:0] irqn, irqoe, raise;
  logic [1:0] mode;
  int num_errors, num_checks, pend, cyc;
  logic [7:0] fq[$];
  // open-drain lines: low only where enabled, pulled up otherwise
  wire ack_low = ackoe & !ackn;
  wire [3:0] irq_low = irqoe & ~irqn;
  ics_slave DUT (.clock_i, .reset_n_i, .chan_addr_i(addr), .chan_data_i(bus),
    .chan_data_o(cdo), .chan_data_oe_o(cdoe), .write_sel_n_i(wr_n), .xfer_strobe_n_i(stb_n),
    .xfer_ack_n_o(ackn), .xfer_ack_oe_o(ackoe), .chan_reset_n_i, .irq_req_n_o(irqn),
    .irq_req_oe_o(irqoe), .clr_mode_i(mode), .irq_raise_i(raise), .rd_byte_i(rdb),
    .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i);
  ics_master m (.clock_i, .ack_i(ack_low), .sdata_i(cdo), .sdata_oe_i(cdoe), .addr_o(addr),
    .data_o(bus), .wr_n_o(wr_n), .stb_n_o(stb_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // expected status: pending lines, highest pending line number, any
  function automatic logic [7:0] stat(input int p);
    int h;
    h = 0;
    for (int i = 0; i < 4; i++) begin
      if (p[i]) h = i + 1;
    end
    return {p != 0, h[2:0], p[3:0]};
  endfunction
  task automatic raise_irq(input logic [3:0] r);
    @(posedge clock_i);
    #1 raise = r;
    pend = pend | r;
    @(posedge clock_i);
    #1 raise = 4'h0;
  endtask
  task automatic pop;
    @(posedge clock_i);
    #1;
    chk("rx head", fq.pop_front(), rxd);
    rx_ready_i = 1'b1;
    @(posedge clock_i);
    #1 rx_ready_i = 1'b0;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    {reset_n_i, rx_ready_i, raise, mode, rdb, num_errors, num_checks, pend, cyc} = '0;
    chan_reset_n_i = 1'b1;
    void'($urandom(23));
    repeat (10) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    chk("idle outputs", 8'h00, {irqoe, 2'b00, ackoe, cdoe});
    mode = 2'b01;
    for (int i = 1; i < 16; i++) begin
      raise_irq(i[3:0]);
      m.xfer(1'b0, 12'h301, 8'h00, q, ok);
      chk("status", stat(pend), q);
      pend = 0;
      chk("irq after read", 8'h00, {4'h0, irq_low});
    end
    $display("read clear done");
    mode = 2'b10;
    repeat (8) begin
      raise_irq(4'($urandom));
      d = 8'($urandom);
      m.xfer(1'b0, 12'h301, 8'h00, q, ok);
      chk("status kept", stat(pend), q);
      m.xfer(1'b1, 12'h302, d, q, ok);
      pend = pend & ~d[3:0];
      chk("irq after write", {4'h0, pend[3:0]}, {4'h0, irq_low});
    end
    $display("write clear done");
    mode = 2'b00;
    raise_irq(4'hF);
    m.xfer(1'b1, 12'h302, 8'hFF, q, ok);
    chk("irq held", 8'h0F, {4'h0, irq_low});
    #1 chan_reset_n_i = 1'b0;
    raise = 4'h5;
    repeat (6) @(posedge clock_i);
    #1 raise = 4'h0;
    chan_reset_n_i = 1'b1;
    chk("irq after channel reset", 8'h00, {4'h0, irq_low});
    m.xfer(1'b0, 12'h301, 8'h00, q, ok);
    chk("status after reset", 8'h00, q);
    rdb = 8'($urandom);
    m.xfer(1'b0, 12'h300, 8'h00, q, ok);
    chk("data read", rdb, q);
    m.xfer(1'b0, 12'h303, 8'h00, q, ok);
    chk("unmapped ack", 8'h00, {7'h00, ok});
    m.xfer(1'b1, 12'($urandom) & 12'h2FF, 8'h00, q, ok);
    chk("foreign ack", 8'h00, {7'h00, ok});
    $display("address decode done");
    for (int i = 0; i < 17; i++) begin
      d = 8'($urandom);
      fq.push_back(d);
      m.linger = i % 3;
      if (i < 16) begin
        m.xfer(1'b1, 12'h300, d, q, ok);
      end else begin
        fork
          m.xfer(1'b1, 12'h300, d, q, ok);
          begin
            repeat (30) @(posedge clock_i);
            chk("ack while full", 8'h00, {7'h00, ackoe});
            pop;
          end
        join
      end
      chk("write ack", 8'h01, {7'h00, ok});
    end
    repeat (16) pop;
    @(posedge clock_i);
    chk("rx empty", 8'h00, {7'h00, rxv});
    $display("buffer done");
    print_verdict;
  end
endmodule
